/* pulse_qualifier.sv */
// pulse_qualifier: two-flop synchroniser followed by a minimum-width filter.
// assumes din is asynchronous to ref_clk and active high.
`timescale 1ns/100ps
`default_nettype none
module pulse_qualifier #(
  parameter int MIN_CYC = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // level in and qualified level out
  input wire logic din,
  output logic qual_ff
);
  localparam int CW = $clog2(MIN_CYC + 1);
  localparam logic [CW-1:0] LIMIT = CW'(MIN_CYC);

  initial begin
    if (MIN_CYC < 1) $error("pulse_qualifier: MIN_CYC must be at least 1");
  end

  logic meta_ff;
  logic sync_ff;
  logic [CW-1:0] cnt_ff;

  // two-flop synchroniser
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  // width counter: qualifies after MIN_CYC active samples, drops at once
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt_ff <= '0;
      qual_ff <= 1'b0;
    end else if (!sync_ff) begin
      cnt_ff <= '0;
      qual_ff <= 1'b0;
    end else if (cnt_ff != LIMIT) begin
      cnt_ff <= cnt_ff + CW'(1);
      qual_ff <= (cnt_ff + CW'(1)) == LIMIT;
    end
  end

endmodule : pulse_qualifier
`default_nettype wire

/* reset_seq_pkg.sv */
// reset_seq_pkg: register map, field positions, fuse codes and timing counts
// for the reset source sequencer.
// assumes a 50 MHz ref_clk and a 32-bit Avalon-MM register port.
package reset_seq_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  // shortest pin pulse that must be caught (rounds down)
  localparam int PIN_MIN_PULSE_NS = 1500;
  localparam int PIN_FILTER_CYC = (PIN_MIN_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  PIN_MIN_PULSE_NS / CLK_PERIOD_NS;
  // least brown-out pulse width (rounds up)
  localparam int BOD_MIN_PULSE_NS = 2000;
  localparam int BOD_FILTER_CYC = (BOD_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // shortest start-up delay step; fuses scale it by a power of two
  localparam int STARTUP_BASE_NS = 64000;
  localparam int STARTUP_BASE_CYC = (STARTUP_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY_CNT_W = 20;

  // ------------------------------------------------------------------
  // register map (byte addresses) and fields
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_CAUSE = 4'h0; // reset_cause_status
  localparam logic [3:0] ADDR_STATE = 4'h4; // sequencer state, read only
  localparam int POWERON_BIT = 0;
  localparam int PIN_BIT = 1;
  localparam int BROWNOUT_BIT = 2;
  localparam int WATCHDOG_BIT = 3;
  localparam int TESTPORT_BIT = 4;
  localparam int CAUSE_W = 5;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 5'h00;
  // state register: bit 0 core reset, bit 1 io hold, bit 2 delay busy,
  // bits 7:3 live source levels
  localparam int STATE_CORE_BIT = 0;
  localparam int STATE_IO_BIT = 1;
  localparam int STATE_BUSY_BIT = 2;
  localparam int STATE_SRC_LSB = 3;

  // ------------------------------------------------------------------
  // brown-out level fuse codes
  // ------------------------------------------------------------------
  localparam logic [2:0] BOD_OFF = 3'h7;
  localparam logic [2:0] BOD_LOW = 3'h6;
  localparam logic [2:0] BOD_MID = 3'h5;
  localparam logic [2:0] BOD_HIGH = 3'h4;

endpackage : reset_seq_pkg

/* reset_seq_sva.sv */
// reset_seq_sva: port-level checks of the reset source sequencer.
// assumes binding to reset_source_sequencer, ref_clk domain only.
`timescale 1ns/100ps
`default_nettype none
module reset_seq_sva
  import reset_seq_pkg::*;
#(
  parameter int DELAY_BASE_CYCLES = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // sources and fuse
  input wire logic supply_low,
  input wire logic reset_pin_n,
  input wire logic watchdog_expire,
  input wire logic testport_reset_reg,
  input wire logic [2:0] brownout_level_fuse,
  // outputs
  input wire logic core_reset_ff,
  input wire logic port_reset_ff,
  input wire logic [2:0] brownout_detector_ff,
  // bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata_ff,
  input wire logic avs_waitrequest_ff
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest_ff;
  endsequence
  sequence s_ack;
    !avs_waitrequest_ff ##1 avs_waitrequest_ff;
  endsequence
  a_pin_port_hold: assert property (!reset_pin_n |-> port_reset_ff)
    else $error("port reset low while pin low");
  a_supply_port_hold: assert property (supply_low |-> port_reset_ff)
    else $error("port reset low while supply low");
  a_supply_core_set: assert property (supply_low |-> ##[1:4] core_reset_ff)
    else $error("supply low gave no core reset");
  a_watchdog_core_set: assert property ($rose(watchdog_expire) |-> ##[1:3] core_reset_ff)
    else $error("watchdog gave no core reset");
  a_testport_core_hold: assert property (testport_reset_reg [*4] |-> core_reset_ff)
    else $error("core released while test port held");
  a_core_stretch: assert property ($fell(testport_reset_reg) |-> core_reset_ff [*4])
    else $error("core released without delay");
  a_one_wait_state: assert property (s_req |=> s_ack)
    else $error("bus answer timing wrong");
  a_cause_top_zero: assert property (avs_read && !avs_waitrequest_ff &&
    avs_address == ADDR_CAUSE |-> avs_readdata_ff[31:5] == 27'h0)
    else $error("cause upper bits not zero");
  a_bod_code_on: assert property (($stable(brownout_level_fuse) && brownout_level_fuse[2]) [*5]
    |-> brownout_detector_ff == brownout_level_fuse)
    else $error("detector code differs from fuse");
  a_bod_code_rsvd: assert property (($stable(brownout_level_fuse) && !brownout_level_fuse[2])
    [*5] |-> brownout_detector_ff == BOD_OFF)
    else $error("reserved fuse code enabled detector");
endmodule : reset_seq_sva

bind reset_source_sequencer reset_seq_sva #(.DELAY_BASE_CYCLES(DELAY_BASE_CYCLES)) u_sva (
  .ref_clk(ref_clk), .rst_b(rst_b), .supply_low(supply_low), .reset_pin_n(reset_pin_n),
  .watchdog_expire(watchdog_expire), .testport_reset_reg(testport_reset_reg),
  .brownout_level_fuse(brownout_level_fuse), .core_reset_ff(core_reset_ff),
  .port_reset_ff(port_reset_ff), .brownout_detector_ff(brownout_detector_ff),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata_ff(avs_readdata_ff), .avs_waitrequest_ff(avs_waitrequest_ff));
`default_nettype wire

/* reset_source_sequencer.sv */
// reset_source_sequencer: merges five reset sources into the core and
// port resets, stretches the release and records the cause.
// assumes detector levels and the pin arrive asynchronously, the watchdog
// pulse and the register port run on ref_clk.
//
// How it works
// - core reset returns registers, then vector start
// - port hold set asynchronously by supply-low and pin, no clock needed
// - fuse-selected delay after all sources inactive
// - five sources, any one asserts reset
// - pin low beyond minimum width resets
// - pin release starts full delay count
// - test-port register one holds reset
// - watchdog gives one-cycle pulse, delay after
// - supply-low resets at once, delay on release
// - brown-out fuse 111 off, 110-100 levels
// - brown-out resets after minimum width, full delay after
// - brown-out shorter than minimum width ignored
// - bit 4 test-port flag, cleared poweron/zero
// - bit 3 watchdog flag, cleared poweron/zero
// - bit 2 brown-out flag, cleared poweron/zero
// - bit 1 pin flag, cleared poweron/zero
// - bit 0 poweron flag, cleared only by zero
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module reset_source_sequencer
  import reset_seq_pkg::*;
#(
  parameter int DELAY_BASE_CYCLES = STARTUP_BASE_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // reset sources
  input wire logic supply_low,
  input wire logic reset_pin_n,
  input wire logic watchdog_expire,
  input wire logic brownout_low,
  input wire logic testport_reset_reg,
  // fuses
  input wire logic [2:0] brownout_level_fuse,
  input wire logic [1:0] startup_time_fuse,
  input wire logic [3:0] clock_select_fuse,
  // reset outputs
  output logic core_reset_ff,
  output logic port_reset_ff,
  output logic [2:0] brownout_detector_ff,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata_ff,
  output logic avs_waitrequest_ff
);
  initial begin
    if (DELAY_BASE_CYCLES < 1 || (DELAY_BASE_CYCLES << 7) >= (1 << DELAY_CNT_W))
      $error("reset_source_sequencer: DELAY_BASE_CYCLES out of range");
  end

  // ------------------------------------------------------------------
  // synchronisers for levels without a width filter
  // ------------------------------------------------------------------
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] meta_ff;
  logic [NSYNC-1:0] sync_ff;
  assign raw_in = {supply_low, testport_reset_reg, brownout_level_fuse,
                   startup_time_fuse, clock_select_fuse};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= raw_in[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  logic poweron_src;
  logic testport_src;
  logic [2:0] bod_fuse;
  logic [1:0] sut_fuse;
  logic [3:0] clock_select_fuse_fuse;
  assign poweron_src = sync_ff[10];
  assign testport_src = sync_ff[9];
  assign bod_fuse = sync_ff[8:6];
  assign sut_fuse = sync_ff[5:4];
  assign clock_select_fuse_fuse = sync_ff[3:0];

  // ------------------------------------------------------------------
  // qualified pin and brown-out sources
  // ------------------------------------------------------------------
  logic pin_src;
  logic bod_qual;
  logic bod_enable;
  logic brownout_src;

  // pin must stay low for the minimum pulse width
  pulse_qualifier #(.MIN_CYC(PIN_FILTER_CYC)) u_pin_qual (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .din(!reset_pin_n),
    .qual_ff(pin_src)
  );

  // brown-out glitches shorter than the minimum width are dropped
  pulse_qualifier #(.MIN_CYC(BOD_FILTER_CYC)) u_bod_qual (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .din(brownout_low),
    .qual_ff(bod_qual)
  );

  // only the three level codes enable detection; off and reserved do not
  always_comb begin
    case (bod_fuse)
      BOD_LOW, BOD_MID, BOD_HIGH: bod_enable = 1'b1;
      default: bod_enable = 1'b0;
    endcase
  end
  assign brownout_src = bod_enable & bod_qual;

  // level select towards the analog detector, BOD_OFF (all ones) when off
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      brownout_detector_ff <= BOD_OFF;
    end else begin
      brownout_detector_ff <= bod_enable ? bod_fuse : BOD_OFF;
    end
  end

  // ------------------------------------------------------------------
  // watchdog pulse
  // ------------------------------------------------------------------
  logic wdt_pulse_ff;
  logic wdt_prev_ff;

  // one system clock cycle wide on the rising expiry level, so a held
  // expiry gives a single pulse; the delay starts as the pulse falls
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wdt_prev_ff <= 1'b0;
      wdt_pulse_ff <= 1'b0;
    end else begin
      wdt_prev_ff <= watchdog_expire;
      wdt_pulse_ff <= watchdog_expire & !wdt_prev_ff;
    end
  end

  // ------------------------------------------------------------------
  // source merge and release delay
  // ------------------------------------------------------------------
  logic [CAUSE_W-1:0] src_vec;
  logic any_src;
  logic [2:0] delay_shift;
  logic [DELAY_CNT_W-1:0] delay_period;
  logic delay_busy;

  assign src_vec[POWERON_BIT] = poweron_src;
  assign src_vec[PIN_BIT] = pin_src;
  assign src_vec[BROWNOUT_BIT] = brownout_src;
  assign src_vec[WATCHDOG_BIT] = wdt_pulse_ff;
  assign src_vec[TESTPORT_BIT] = testport_src;
  assign any_src = |src_vec;

  // start-up and clock-select fuses pick the stretch length
  assign delay_shift = {sut_fuse, clock_select_fuse_fuse[0]};
  assign delay_period = DELAY_CNT_W'(DELAY_BASE_CYCLES) << delay_shift;

  // reloads while any source is active, counts once all are released
  startup_delay #(.CNT_W(DELAY_CNT_W)) u_delay (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .hold(any_src),
    .period(delay_period),
    .busy_ff(delay_busy)
  );

  // core reset: held by sources, then by the delay counter
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      core_reset_ff <= 1'b1;
    end else begin
      core_reset_ff <= any_src | delay_busy;
    end
  end

  // ------------------------------------------------------------------
  // asynchronous port hold
  // ------------------------------------------------------------------
  logic async_src;
  assign async_src = supply_low | !reset_pin_n;

  // set straight from the raw pins so ports reset without any clock;
  // released synchronously together with the core
  always_ff @(posedge ref_clk or posedge async_src) begin
    if (async_src) begin
      port_reset_ff <= 1'b1;
    end else if (!rst_b) begin
      port_reset_ff <= 1'b1;
    end else begin
      port_reset_ff <= any_src | delay_busy;
    end
  end

  // ------------------------------------------------------------------
  // avalon-mm slave: one wait state on every access
  // ------------------------------------------------------------------
  logic req;
  logic accept;
  logic cause_wr;
  assign req = avs_read | avs_write;
  assign accept = req & !avs_waitrequest_ff;
  assign cause_wr = avs_write & accept & avs_byteenable[0] & (avs_address == ADDR_CAUSE);

  // waitrequest drops for one cycle after a request is seen
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      avs_waitrequest_ff <= 1'b1;
    end else begin
      avs_waitrequest_ff <= !(req & avs_waitrequest_ff);
    end
  end

  // ------------------------------------------------------------------
  // reset cause flags
  // ------------------------------------------------------------------
  logic [CAUSE_W-1:0] cause_ff;
  logic [CAUSE_W-1:0] nxt_cause;
  logic [CAUSE_W-1:0] wr_clear;

  // zero written clears, one written keeps; set always wins
  always_comb begin
    wr_clear = cause_wr ? ~avs_writedata[CAUSE_W-1:0] : '0;
    nxt_cause = cause_ff & ~wr_clear;
    if (poweron_src) begin
      nxt_cause = '0;
    end
    nxt_cause = nxt_cause | src_vec;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cause_ff <= CAUSE_RESET;
    end else begin
      cause_ff <= nxt_cause;
    end
  end

  // read data is loaded with the request and stands on the answer edge
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      avs_readdata_ff <= 32'h0000_0000;
    end else if (avs_read & avs_waitrequest_ff) begin
      case (avs_address)
        ADDR_CAUSE: avs_readdata_ff <= {27'h0000000, cause_ff};
        ADDR_STATE: avs_readdata_ff <= {24'h000000, src_vec, delay_busy,
                                        port_reset_ff, core_reset_ff};
        default: avs_readdata_ff <= 32'h0000_0000;
      endcase
    end
  end

endmodule : reset_source_sequencer
`default_nettype wire

/* reset_src_model.sv */
// reset_src_model: pin, supply monitors, watchdog and test port levels.
// assumes the bench calls its tasks just after a rising ref_clk edge.
`timescale 1ns/100ps
`default_nettype none
module reset_src_model (
  // clock
  input wire logic ref_clk,
  // source levels
  output var logic supply_low,
  output var logic reset_pin_n,
  output var logic watchdog_expire,
  output var logic brownout_low,
  output var logic testport_reset_reg
);
  // all sources inactive at power-up of the bench
  initial begin
    supply_low = 1'b0;
    reset_pin_n = 1'b1;
    watchdog_expire = 1'b0;
    brownout_low = 1'b0;
    testport_reset_reg = 1'b0;
  end
  // drive one source to its active or idle level
  task automatic set_src(input int src, input logic lvl);
    case (src)
      0: supply_low <= lvl;
      1: reset_pin_n <= !lvl;
      2: watchdog_expire <= lvl;
      3: brownout_low <= lvl;
      default: testport_reset_reg <= lvl;
    endcase
  endtask : set_src
  // hold a source active for a number of cycles
  task automatic assert_src(input int src, input int cyc);
    @(posedge ref_clk);
    set_src(src, 1'b1);
    repeat (cyc) @(posedge ref_clk);
    set_src(src, 1'b0);
  endtask : assert_src
endmodule : reset_src_model
`default_nettype wire

/* startup_delay.sv */
// startup_delay: stretches reset for a loaded period after hold drops.
// assumes period is stable while hold is high.
`timescale 1ns/100ps
`default_nettype none
module startup_delay #(
  parameter int CNT_W = 20
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // control
  input wire logic hold,
  input wire logic [CNT_W-1:0] period,
  // status
  output logic busy_ff
);
  initial begin
    if (CNT_W < 2) $error("startup_delay: CNT_W too small");
  end

  logic [CNT_W-1:0] cnt_ff;

  // reload while any source holds; count down once all have let go
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt_ff <= period;
      busy_ff <= 1'b1;
    end else if (hold) begin
      cnt_ff <= period;
      busy_ff <= 1'b1;
    end else if (cnt_ff > CNT_W'(1)) begin
      cnt_ff <= cnt_ff - CNT_W'(1);
    end else begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
    end
  end

endmodule : startup_delay
`default_nettype wire

/* tb_top.sv */
// tb_top: bus and reset source tests of the reset source sequencer.
// assumes reset_src_model for the sources and a 4-cycle delay base.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import reset_seq_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0;
  logic [2:0] bod_fuse = 3'h7;
  logic [1:0] sut_fuse = 2'h0;
  logic [3:0] cks_fuse = 4'h0;
  wire logic sup, pin_n, wdog, brownout_detector, tport, core, port, waitreq;
  wire logic [2:0] bod_code;
  wire logic [31:0] rdata;
  int num_errors = 0;
  int check_count = 0;
  int n;
  logic [31:0] rd;

  // 50 MHz clock
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  reset_src_model src (.ref_clk(ref_clk), .supply_low(sup), .reset_pin_n(pin_n),
    .watchdog_expire(wdog), .brownout_low(brownout_detector), .testport_reset_reg(tport));
  reset_source_sequencer #(.DELAY_BASE_CYCLES(4)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .supply_low(sup), .reset_pin_n(pin_n), .watchdog_expire(wdog), .brownout_low(brownout_detector),
    .testport_reset_reg(tport), .brownout_level_fuse(bod_fuse), .startup_time_fuse(sut_fuse),
    .clock_select_fuse(cks_fuse), .core_reset_ff(core), .port_reset_ff(port),
    .brownout_detector_ff(bod_code), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata_ff(rdata), .avs_waitrequest_ff(waitreq));

  // compare one value and count it
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge ref_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    q = rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50) chk("bus answer", 32'h1, 32'h0);
  endtask : bus
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd);
    chk(what, exp, rd);
  endtask : rd_chk
  // cycles until the core reset drops, bounded
  task automatic wait_core(output int c);
    c = 4;
    repeat (4) @(posedge ref_clk);
    while (core !== 1'b0 && c < 3000) begin
      @(posedge ref_clk);
      c++;
    end
  endtask : wait_core
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // hang guard
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    wait_core(n);
    chk("core idle", 32'h0, {31'h0, core});
    rd_chk("unmapped", 4'h8, 32'h0);
    rd_chk("state idle", ADDR_STATE, 32'h0);
    src.assert_src(2, 1);
    wait_core(n);
    rd_chk("wd flag", ADDR_CAUSE, 32'h08);
    bus(1'b1, ADDR_CAUSE, 32'hffff_fff7, rd);
    rd_chk("wd clear", ADDR_CAUSE, 32'h0);
    src.assert_src(1, 80);
    wait_core(n);
    rd_chk("pin flag", ADDR_CAUSE, 32'h02);
    bus(1'b1, ADDR_CAUSE, 32'h0, rd);
    src.assert_src(1, 20);
    wait_core(n);
    rd_chk("pin short", ADDR_CAUSE, 32'h0);
    $display("test pin done");
    for (int i = 0; i < 8; i++) begin
      bod_fuse <= i[2:0];
      repeat (6) @(posedge ref_clk);
      chk("bod code", {29'h0, i[2] ? i[2:0] : BOD_OFF}, {29'h0, bod_code});
    end
    bod_fuse <= BOD_LOW;
    src.assert_src(3, 50);
    wait_core(n);
    rd_chk("bod glitch", ADDR_CAUSE, 32'h0);
    src.assert_src(3, 110);
    wait_core(n);
    rd_chk("bod flag", ADDR_CAUSE, 32'h04);
    bus(1'b1, ADDR_CAUSE, 32'h0, rd);
    bod_fuse <= BOD_OFF;
    src.assert_src(3, 110);
    wait_core(n);
    rd_chk("bod off", ADDR_CAUSE, 32'h0);
    $display("test brownout done");
    sut_fuse <= 2'h3;
    cks_fuse <= 4'h1;
    src.set_src(4, 1'b1);
    repeat (8) @(posedge ref_clk);
    bus(1'b1, ADDR_CAUSE, 32'h0, rd);
    chk("core held", 32'h1, {31'h0, core});
    chk("port held", 32'h1, {31'h0, port});
    rd_chk("tp flag", ADDR_CAUSE, 32'h10);
    src.set_src(4, 1'b0);
    wait_core(n);
    chk("long delay", 32'h1, {31'h0, n >= 512 && n <= 522});
    avs_byteenable <= 4'he;
    bus(1'b1, ADDR_CAUSE, 32'h0, rd);
    avs_byteenable <= 4'hf;
    rd_chk("lane off", ADDR_CAUSE, 32'h10);
    sut_fuse <= 2'h0;
    cks_fuse <= 4'h0;
    src.assert_src(0, 10);
    wait_core(n);
    rd_chk("poweron", ADDR_CAUSE, 32'h01);
    src.assert_src(1, 80);
    wait_core(n);
    rd_chk("por kept", ADDR_CAUSE, 32'h03);
    bus(1'b1, ADDR_CAUSE, 32'h0, rd);
    rd_chk("por clear", ADDR_CAUSE, 32'h0);
    $display("test testport and poweron done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
